/* design/test_io_condition_branch.sv */
// Purpose: Decode and condition select for the test-and-branch operation
// Assumes: Status inputs are synchronous levels from the attachments
// Notes:   One instruction at a time; result two edges after issue
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module test_io_condition_branch
  import tio_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  input  wire logic                    issue_valid,
  output logic                         issue_ready,
  input  wire tio_pkg::instr_t         issue_instr,
  input  wire tio_pkg::attach_status_t attach_status,
  output tio_pkg::result_t             result,
  output logic                         irq,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);
  import tio_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fsm_t            fsm;
    instr_t          instr;
    attach_status_t  snap;
    result_t         res;
    logic            model15;
    logic [EV_W-1:0] ev_status;
    logic [EV_W-1:0] ev_enable;
    logic            aw_got;
    logic [7:0]      aw_addr;
    logic            w_got;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [31:0]     rdata;
  } state_t;

  state_t cur;
  state_t next_cur;

  // Decode helpers (combinational)
  logic [3:0]      unit;
  logic            modifier;
  logic [2:0]      cond_code;
  logic [1:0]      drive;
  logic            cond;
  logic            valid_q;
  logic            acq_att_any;
  logic [15:0]     target;
  logic [EV_W-1:0] ev_set;
  logic [31:0]     read_word;
  logic            read_ok;
  logic            do_write;

  // ----------------------------------------------------------------
  // Field split and condition select
  // ----------------------------------------------------------------
  // Fields come from the latched Q byte, never from the live input
  assign unit      = cur.instr.q_byte[Q_UNIT_HI:Q_UNIT_LO];
  assign modifier  = cur.instr.q_byte[Q_MOD_BIT];
  assign cond_code = cur.instr.q_byte[Q_N_HI:0];
  assign drive     = {unit[0], modifier};

  // Any diagnostic check also raises the attachment check
  assign acq_att_any = cur.snap.acq_att_chk | cur.snap.acq_buf_chk |
                       cur.snap.acq_cs_chk | cur.snap.acq_addr_chk |
                       cur.snap.acq_wr_chk;

  always_comb
  begin
    cond    = 1'b0;
    valid_q = 1'b1;
    case (unit)
      UNIT_READER:
      begin
        if (!modifier)
          valid_q = 1'b0;
        else
        begin
          case (cond_code)
            N_NOT_READY: cond = cur.snap.reader_not_ready;
            N_BUSY:      cond = cur.snap.reader_busy;
            N_INT_PEND:
            begin
              // Only the larger model carries this line
              cond    = cur.model15 & cur.snap.reader_int_pend;
              valid_q = cur.model15;
            end
            default:     valid_q = 1'b0;
          endcase
        end
      end
      UNIT_PUNCH:
      begin
        if (!modifier)
        begin
          case (cond_code)
            N_NOT_READY: cond = cur.snap.punch_not_ready;
            N_BUSY:      cond = cur.snap.punch_busy;
            default:     valid_q = 1'b0;
          endcase
        end
        else
        begin
          case (cond_code)
            N_NOT_READY: cond = cur.snap.acq_not_ready;
            N_BUF_CHK:   cond = cur.snap.acq_buf_chk;
            N_CS_CHK:    cond = cur.snap.acq_cs_chk;
            N_ADDR_CHK:  cond = cur.snap.acq_addr_chk;
            N_WR_CHK:    cond = cur.snap.acq_wr_chk;
            N_ATT_CHK:   cond = acq_att_any;
            default:     valid_q = 1'b0;
          endcase
        end
      end
      UNIT_SCREEN:
      begin
        // Modifier deliberately ignored for the screen
        if (cond_code[N_MID_BIT])
          cond = cur.snap.screen_busy;
        else
          cond = cur.snap.screen_check;
      end
      UNIT_FDISK_1, UNIT_FDISK_2:
      begin
        case (cond_code)
          N_NOT_READY:  cond = cur.snap.fdisk_not_ready[drive];
          N_BUSY:       cond = cur.snap.fdisk_xfer_busy[drive];
          N_SCAN_FOUND: cond = cur.snap.fdisk_scan_found[drive];
          default:      valid_q = 1'b0;
        endcase
      end
      UNIT_MDISK_1, UNIT_MDISK_2:
      begin
        case (cond_code)
          N_NOT_READY: cond = cur.snap.mdisk_not_ready[drive];
          N_SEEK_BUSY: cond = cur.snap.mdisk_seek_busy[drive];
          N_ATT_BUSY:  cond = cur.snap.mdisk_att_busy[drive];
          N_SCAN_HIT:  cond = cur.snap.mdisk_scan_hit[drive];
          default:     valid_q = 1'b0;
        endcase
      end
      default: valid_q = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Branch target formation
  // ----------------------------------------------------------------
  // Displacement is unsigned; the sum wraps within 16 bits
  always_comb
  begin
    target = cur.instr.seq_addr;
    case (cur.instr.opcode)
      OP_DIRECT: target = {cur.instr.operand_hi,
                           cur.instr.operand_lo};
      OP_IDX1:   target = 16'(cur.instr.index_reg_one +
                              {8'h00, cur.instr.operand_hi});
      OP_IDX2:   target = 16'(cur.instr.index_reg_two +
                              {8'h00, cur.instr.operand_hi});
      default:   target = cur.instr.seq_addr;
    endcase
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    read_word = 32'h0000_0000;
    read_ok   = 1'b1;
    case (s_axi_araddr)
      REG_CTRL:    read_word[CTRL_MODEL15] = cur.model15;
      REG_STATUS:  read_word[EV_W-1:0] = cur.ev_status;
      REG_INT_EN:  read_word[EV_W-1:0] = cur.ev_enable;
      REG_INT_CLR: read_word = 32'h0000_0000;  // Write-only
      REG_LAST:
      begin
        read_word[15:0]         = cur.res.next_addr;
        read_word[LAST_TAKEN]   = cur.res.taken;
        read_word[LAST_INVALID] = cur.res.invalid_q;
      end
      default:     read_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  assign do_write = cur.aw_got & cur.w_got & ~cur.bvalid;

  always_comb
  begin
    next_cur          = cur;
    next_cur.res.done = 1'b0;
    ev_set            = '0;

    // Instruction sequencing
    case (cur.fsm)
      ST_IDLE:
      begin
        if (issue_valid)
        begin
          // Single snapshot; status lines are only read, never cleared
          next_cur.instr = issue_instr;
          next_cur.snap  = attach_status;
          next_cur.fsm   = ST_EVAL;
        end
      end
      ST_EVAL:
      begin
        next_cur.res.done      = 1'b1;
        next_cur.res.invalid_q = ~valid_q;
        next_cur.res.taken     = valid_q & cond;
        if (valid_q & cond)
          next_cur.res.next_addr = target;
        else
          next_cur.res.next_addr = cur.instr.seq_addr;
        ev_set[EV_TAKEN]     = valid_q & cond;
        ev_set[EV_NOT_TAKEN] = valid_q & ~cond;
        ev_set[EV_INVALID]   = ~valid_q;
        next_cur.fsm = ST_IDLE;
      end
      default: next_cur.fsm = ST_IDLE;
    endcase

    // Bus write channels, taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_cur.aw_got  = 1'b1;
      next_cur.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_cur.w_got  = 1'b1;
      next_cur.w_data = s_axi_wdata;
      next_cur.w_strb = s_axi_wstrb;
    end
    if (do_write)
    begin
      next_cur.aw_got = 1'b0;
      next_cur.w_got  = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp  = RESP_OKAY;
      case (cur.aw_addr)
        REG_CTRL:
          if (cur.w_strb[0])
            next_cur.model15 = cur.w_data[CTRL_MODEL15];
        REG_INT_EN:
          if (cur.w_strb[0])
            next_cur.ev_enable = cur.w_data[EV_W-1:0];
        REG_INT_CLR:
          if (cur.w_strb[0])
            next_cur.ev_status = cur.ev_status & ~cur.w_data[EV_W-1:0];
        REG_STATUS, REG_LAST: next_cur.bresp = RESP_OKAY; // Read-only
        default:  next_cur.bresp = RESP_SLVERR;
      endcase
    end
    else if (cur.bvalid && s_axi_bready)
      next_cur.bvalid = 1'b0;

    // Events set after the clear so a same-cycle event is kept
    next_cur.ev_status = next_cur.ev_status | ev_set;

    // Read channel
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_cur.rvalid = 1'b1;
      next_cur.rdata  = read_word;
      next_cur.rresp  = read_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (cur.rvalid && s_axi_rready)
      next_cur.rvalid = 1'b0;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur         <= '0;
      cur.fsm     <= ST_IDLE;
      cur.model15 <= CTRL_RESET;
      cur.bresp   <= RESP_OKAY;
      cur.rresp   <= RESP_OKAY;
    end
    else
      cur <= next_cur;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign issue_ready   = (cur.fsm == ST_IDLE);
  assign result        = cur.res;
  assign irq           = |(cur.ev_status & cur.ev_enable);
  assign s_axi_awready = ~cur.aw_got & ~cur.bvalid;
  assign s_axi_wready  = ~cur.w_got & ~cur.bvalid;
  assign s_axi_bvalid  = cur.bvalid;
  assign s_axi_bresp   = cur.bresp;
  assign s_axi_arready = ~cur.rvalid;
  assign s_axi_rvalid  = cur.rvalid;
  assign s_axi_rdata   = cur.rdata;
  assign s_axi_rresp   = cur.rresp;

endmodule

/* include/tio_pkg.sv */
// Purpose: Shared constants and carriers for the test-and-branch decoder
// Assumes: Q byte bit 7 is instruction bit 8 (unit select MSB)
// Notes:   Register map sits on a 32-bit AXI4-Lite slave
package tio_pkg;

  // ----------------------------------------------------------------
  // Operation codes and Q-byte fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_DIRECT = 8'hC1; // Two-byte direct target
  localparam logic [7:0] OP_IDX1   = 8'hD1; // Displacement + index one
  localparam logic [7:0] OP_IDX2   = 8'hE1; // Displacement + index two
  localparam int Q_UNIT_HI = 7;
  localparam int Q_UNIT_LO = 4;
  localparam int Q_MOD_BIT = 3;
  localparam int Q_N_HI    = 2;
  localparam int N_MID_BIT = 1;

  // Unit select codes
  localparam logic [3:0] UNIT_READER  = 4'h3;
  localparam logic [3:0] UNIT_PUNCH   = 4'h5;
  localparam logic [3:0] UNIT_SCREEN  = 4'h9;
  localparam logic [3:0] UNIT_FDISK_1 = 4'hA;
  localparam logic [3:0] UNIT_FDISK_2 = 4'hB;
  localparam logic [3:0] UNIT_MDISK_1 = 4'hC;
  localparam logic [3:0] UNIT_MDISK_2 = 4'hD;

  // Condition codes
  localparam logic [2:0] N_NOT_READY  = 3'h0;
  localparam logic [2:0] N_INT_PEND   = 3'h1;
  localparam logic [2:0] N_BUSY       = 3'h2;
  localparam logic [2:0] N_BUF_CHK    = 3'h2;
  localparam logic [2:0] N_CS_CHK     = 3'h3;
  localparam logic [2:0] N_ADDR_CHK   = 3'h4;
  localparam logic [2:0] N_ATT_CHK    = 3'h5;
  localparam logic [2:0] N_WR_CHK     = 3'h6;
  localparam logic [2:0] N_SCAN_FOUND = 3'h4;
  localparam logic [2:0] N_SEEK_BUSY  = 3'h1;
  localparam logic [2:0] N_ATT_BUSY   = 3'h2;
  localparam logic [2:0] N_SCAN_HIT   = 3'h3;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and bit positions
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_INT_EN  = 8'h08;
  localparam logic [7:0] REG_INT_CLR = 8'h0C;
  localparam logic [7:0] REG_LAST    = 8'h10;
  localparam int CTRL_MODEL15 = 0;
  localparam int EV_TAKEN     = 0;
  localparam int EV_NOT_TAKEN = 1;
  localparam int EV_INVALID   = 2;
  localparam int EV_W         = 3;
  localparam int LAST_TAKEN   = 16;
  localparam int LAST_INVALID = 17;
  localparam logic             CTRL_RESET = 1'b0;
  localparam logic [1:0]       RESP_OKAY  = 2'h0;
  localparam logic [1:0]       RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       reader_not_ready;
    logic       reader_int_pend;
    logic       reader_busy;
    logic       punch_not_ready;
    logic       punch_busy;
    logic       acq_not_ready;
    logic       acq_buf_chk;
    logic       acq_cs_chk;
    logic       acq_addr_chk;
    logic       acq_wr_chk;
    logic       acq_att_chk;
    logic       screen_busy;
    logic       screen_check;
    logic [3:0] fdisk_not_ready;
    logic [3:0] fdisk_xfer_busy;
    logic [3:0] fdisk_scan_found;
    logic [3:0] mdisk_not_ready;
    logic [3:0] mdisk_seek_busy;
    logic [3:0] mdisk_att_busy;
    logic [3:0] mdisk_scan_hit;
  } attach_status_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  q_byte;
    logic [7:0]  operand_hi;
    logic [7:0]  operand_lo;
    logic [15:0] index_reg_one;
    logic [15:0] index_reg_two;
    logic [15:0] seq_addr;
  } instr_t;

  typedef struct packed {
    logic        done;
    logic        taken;
    logic        invalid_q;
    logic [15:0] next_addr;
  } result_t;

  typedef enum logic [0:0] {ST_IDLE, ST_EVAL} fsm_t;

endpackage

/* verif/attach_model.sv */
// Purpose: Attachment status source facing the decoder
// Assumes: Status levels move only on a clock edge
// Notes:   Leaves reset showing every condition true, the least kind case
`timescale 1ns/1ns
module attach_model
(
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  input  wire logic                    load,
  input  wire tio_pkg::attach_status_t load_val,
  output tio_pkg::attach_status_t      st
);
  import tio_pkg::*;
  // New levels land one edge after the load request, as a unit would
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      st <= '1;
    else if (load)
      st <= load_val;
  end
endmodule

/* verif/test_io_condition_branch_chk.sv */
// Purpose: Port assertions for the test-and-branch decoder
// Assumes: Result comes two edges after a taken request
// Notes:   Keeps its own copy of each request to judge the result
`timescale 1ns/1ns
module test_io_condition_branch_chk
(
  input wire logic                    clk_sys,
  input wire logic                    reset_n,
  input wire logic                    issue_valid,
  input wire logic                    issue_ready,
  input wire tio_pkg::instr_t         issue_instr,
  input wire tio_pkg::attach_status_t attach_status,
  input wire tio_pkg::result_t        result
);
  import tio_pkg::*;
  instr_t         sv;
  attach_status_t ss;
  logic [3:0]     u;
  logic [2:0]     n;
  logic           m, dn, tk, iv;
  logic [15:0]    na;

  // Copy held from take to done; ready drops so copies never overlap
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      {sv, ss} <= '0;
    else if (issue_valid && issue_ready)
      {sv, ss} <= {issue_instr, attach_status};
  end

  // Fields of the held request and of the result
  assign {u, m, n} = sv.q_byte;
  assign {dn, tk, iv, na} = result;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ----
  // Timing and target
  // ----
  sequence s_take; issue_valid && issue_ready; endsequence
  sequence s_eval; !issue_ready ##1 dn; endsequence
  property p_lat; s_take |=> s_eval; endproperty
  a_lat: assert property (p_lat) else $error("result not on time");
  property p_hold; dn |=> !dn && $stable(na) && $stable(tk); endproperty
  a_hold: assert property (p_hold) else $error("result not held");
  property p_seq; dn && !tk |-> na == sv.seq_addr; endproperty
  a_seq: assert property (p_seq) else $error("bad fall-through");
  property p_dir;
    dn && tk && sv.opcode == OP_DIRECT
      |-> na == {sv.operand_hi, sv.operand_lo};
  endproperty
  a_dir: assert property (p_dir) else $error("bad direct target");
  property p_ix1;
    dn && tk && sv.opcode == OP_IDX1
      |-> na == sv.index_reg_one + {8'h00, sv.operand_hi};
  endproperty
  a_ix1: assert property (p_ix1) else $error("bad index target");
  property p_ix2;
    dn && tk && sv.opcode == OP_IDX2
      |-> na == sv.index_reg_two + {8'h00, sv.operand_hi};
  endproperty
  a_ix2: assert property (p_ix2) else $error("bad index target");
  // ----
  // Condition select
  // ----
  property p_scr;
    dn && u == UNIT_SCREEN
      |-> !iv && tk == (n[1] ? ss.screen_busy : ss.screen_check);
  endproperty
  a_scr: assert property (p_scr) else $error("bad screen test");
  property p_pun;
    dn && u == UNIT_PUNCH && !m && n != 3'h0 && n != 3'h2 |-> iv && !tk;
  endproperty
  a_pun: assert property (p_pun) else $error("code not refused");
  property p_att;
    dn && u == UNIT_PUNCH && m && n == N_ATT_CHK |-> tk == (ss.acq_att_chk
      | ss.acq_buf_chk | ss.acq_cs_chk | ss.acq_addr_chk | ss.acq_wr_chk);
  endproperty
  a_att: assert property (p_att) else $error("bad check sum");
  property p_seek;
    dn && (u == UNIT_MDISK_1 || u == UNIT_MDISK_2) && n == N_SEEK_BUSY
      |-> tk == ss.mdisk_seek_busy[{u[0], m}];
  endproperty
  a_seek: assert property (p_seek) else $error("bad drive pick");
endmodule

bind test_io_condition_branch test_io_condition_branch_chk
  i_test_io_condition_branch_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .issue_valid(issue_valid),
  .issue_ready(issue_ready), .issue_instr(issue_instr),
  .attach_status(attach_status), .result(result));

/* verif/test_io_condition_branch_tb.sv */
// Purpose: Self-checking bench for the test-and-branch decoder
// Assumes: Attachment levels come from the attach_model partner
// Notes:   Random requests plus hand cases; expectations from functions
`timescale 1ns/1ns
module test_io_condition_branch_tb;
  import tio_pkg::*;
  logic           clk_sys = 0, reset_n = 0, iv = 0, ld = 0, m15 = 0;
  logic           rdy, irq, awr, wrd, bv, arr, rv;
  logic           awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [7:0]     aa = '0, ra = '0;
  logic [3:0]     ws = 4'hF;
  logic [31:0]    wd = '0, rd;
  logic [1:0]     bresp, rresp;
  instr_t         ins = '0;
  attach_status_t st, lv = '0;
  result_t        res;
  int             err_total = 0, total_checks = 0;

  test_io_condition_branch i_test_io_condition_branch (
    .clk_sys(clk_sys), .reset_n(reset_n), .issue_valid(iv),
    .issue_ready(rdy), .issue_instr(ins), .attach_status(st),
    .result(res), .irq(irq), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ra),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
  attach_model i_attach_model (.clk_sys(clk_sys), .reset_n(reset_n),
    .load(ld), .load_val(lv), .st(st));

  always #20 clk_sys = ~clk_sys;

  // ----
  // Reporting
  // ----
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // A wait ran out: count it and stop rather than hang
  task automatic hang;
    check(32'h0, 32'h1);
    summarize();
  endtask

  // ----
  // Reference decode: {invalid, taken, next address}
  // ----
  function automatic logic [17:0] expect_res(instr_t i, attach_status_t s,
                                             logic md15);
    logic [3:0]  u;
    logic        m, a, tk;
    logic [2:0]  n;
    logic [1:0]  d;
    logic [7:0]  cv, vm;
    logic [15:0] t;
    {u, m, n} = i.q_byte;
    d = {u[0], m};
    a = s.acq_att_chk | s.acq_buf_chk | s.acq_cs_chk | s.acq_addr_chk
        | s.acq_wr_chk;
    {cv, vm} = 16'h0000;
    case (u)
      UNIT_READER:
      begin
        cv = {5'h00, s.reader_busy, s.reader_int_pend, s.reader_not_ready};
        vm = m ? {5'h00, 1'h1, md15, 1'h1} : 8'h00;
      end
      UNIT_PUNCH:
      begin
        cv = m ? {1'h0, s.acq_wr_chk, a, s.acq_addr_chk, s.acq_cs_chk,
                  s.acq_buf_chk, 1'h0, s.acq_not_ready}
               : {5'h00, s.punch_busy, 1'h0, s.punch_not_ready};
        vm = m ? 8'h7D : 8'h05;
      end
      UNIT_SCREEN:
      begin
        cv = {2{{2{s.screen_busy}}, {2{s.screen_check}}}};
        vm = 8'hFF;
      end
      UNIT_FDISK_1, UNIT_FDISK_2:
      begin
        cv = {3'h0, s.fdisk_scan_found[d], 1'h0, s.fdisk_xfer_busy[d],
              1'h0, s.fdisk_not_ready[d]};
        vm = 8'h15;
      end
      UNIT_MDISK_1, UNIT_MDISK_2:
      begin
        cv = {4'h0, s.mdisk_scan_hit[d], s.mdisk_att_busy[d],
              s.mdisk_seek_busy[d], s.mdisk_not_ready[d]};
        vm = 8'h0F;
      end
      default: ;
    endcase
    case (i.opcode)
      OP_DIRECT: t = {i.operand_hi, i.operand_lo};
      OP_IDX1:   t = i.index_reg_one + {8'h00, i.operand_hi};
      OP_IDX2:   t = i.index_reg_two + {8'h00, i.operand_hi};
      default:   t = i.seq_addr;
    endcase
    tk = vm[n] & cv[n];
    return {~vm[n], tk, tk ? t : i.seq_addr};
  endfunction

  function automatic attach_status_t rnd_st();
    logic [63:0] r;
    r = {$urandom(), $urandom()};
    return attach_status_t'(r[$bits(attach_status_t)-1:0]);
  endfunction

  // Random request; unknown opcodes included, screen modifier kept zero
  function automatic instr_t rnd_ins();
    logic [95:0] r;
    instr_t      i;
    r = {$urandom(), $urandom(), $urandom()};
    i = instr_t'(r[$bits(instr_t)-1:0]);
    case ($urandom_range(3))
      0: i.opcode = OP_DIRECT;
      1: i.opcode = OP_IDX1;
      2: i.opcode = OP_IDX2;
      default: i.opcode = 8'h00;
    endcase
    if (i.q_byte[7:4] == UNIT_SCREEN)
      i.q_byte[3] = 1'h0;
    return i;
  endfunction

  // ----
  // One request; levels change on the capturing edge, so late sampling shows
  // ----
  task automatic run(input instr_t i);
    attach_status_t snap;
    logic [17:0]    got, e;
    logic           ok;
    ok = 0;
    @(posedge clk_sys);
    ins <= i;
    iv <= 1'h1;
    ld <= 1'h1;
    lv <= rnd_st();
    for (int k = 0; k < 20 && !ok; k++)
    begin
      @(negedge clk_sys);
      ok = rdy;
      snap = st;
      @(posedge clk_sys);
    end
    if (!ok)
      hang();
    iv <= 1'h0;
    ld <= 1'h0;
    ok = 0;
    for (int k = 0; k < 8 && !ok; k++)
    begin
      @(negedge clk_sys);
      ok = res.done;
      got = {res.invalid_q, res.taken, res.next_addr};
      @(posedge clk_sys);
    end
    if (!ok)
      hang();
    e = expect_res(i, snap, m15);
    check(32'(got[17:16]), 32'(e[17:16]));
    check(32'(got[15:0]), 32'(e[15:0]));
  endtask

  // ----
  // Register bus master: one write or one read
  // ----
  task automatic axi(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic [1:0] resp);
    logic a_ok, w_ok, fin, sa, sw, sb;
    {a_ok, w_ok, fin} = {1'h0, ~we, 1'h0};
    @(posedge clk_sys);
    if (we)
    begin
      aa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      br <= 1'h1;
    end
    else
    begin
      ra <= a;
      arv <= 1'h1;
      rr <= 1'h1;
    end
    for (int k = 0; k < 20 && !fin; k++)
    begin
      @(negedge clk_sys);
      {sa, sw, sb} = we ? {awr, wrd, bv} : {arr, 1'h0, rv};
      q = rd;
      resp = we ? bresp : rresp;
      @(posedge clk_sys);
      if (sa && !a_ok)
      begin
        a_ok = 1'h1;
        awv <= 1'h0;
        arv <= 1'h0;
      end
      if (sw && !w_ok)
      begin
        w_ok = 1'h1;
        wv <= 1'h0;
      end
      if (sb)
      begin
        fin = 1'h1;
        br <= 1'h0;
        rr <= 1'h0;
      end
    end
    if (!fin)
      hang();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0]  r;
    axi(1'h1, a, d, q, r);
    check(32'(r), 32'(a > REG_LAST ? RESP_SLVERR : RESP_OKAY));
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  r;
    axi(1'h0, a, 32'h0, q, r);
    check(q, e);
    check(32'(r), 32'(er));
  endtask

  task automatic irq_is(input logic e);
    for (int k = 0; k < 8 && irq !== e; k++)
      @(negedge clk_sys);
    check(32'(irq), 32'(e));
  endtask

  // Main sequence
  initial
  begin
    instr_t     h;
    logic [7:0] qs [6];
    qs = '{8'h39, 8'h92, 8'h90, 8'h5D, 8'h51, 8'hE0};
    void'($urandom(62405));
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'h1;
    for (int a = 0; a < 6; a++)
      rdc(8'(a * 4), 32'h0, a == 5 ? RESP_SLVERR : RESP_OKAY);
    wr(REG_STATUS, 32'hFFFFFFFF);
    wr(REG_LAST + 8'h04, 32'hFFFFFFFF);
    // A write with lane zero off must leave the register alone
    ws <= 4'h0;
    wr(REG_INT_EN, 32'h7);
    ws <= 4'hF;
    rdc(REG_INT_EN, 32'h0, RESP_OKAY);
    rdc(REG_STATUS, 32'h0, RESP_OKAY);
    $display("test registers done");
    h = rnd_ins();
    h.opcode = OP_IDX1;
    h.index_reg_one = 16'hFFF0;
    h.operand_hi = 8'h20;
    foreach (qs[j])
    begin
      h.q_byte = qs[j];
      run(h);
    end
    $display("test corner cases done");
    for (int k = 0; k < 160; k++)
    begin
      if (k == 80)
      begin
        wr(REG_CTRL, 32'h1);
        m15 = 1'h1;
        h.q_byte = 8'h39;
        run(h);
      end
      run(rnd_ins());
    end
    $display("test random done");
    wr(REG_INT_CLR, 32'h7);
    wr(REG_INT_EN, 32'h4);
    irq_is(1'h0);
    h.q_byte = 8'hE0;
    run(h);
    irq_is(1'h1);
    rdc(REG_STATUS, 32'h4, RESP_OKAY);
    rdc(REG_LAST, {14'h0, 2'h2, h.seq_addr}, RESP_OKAY);
    wr(REG_INT_EN, 32'h0);
    irq_is(1'h0);
    wr(REG_INT_EN, 32'h4);
    irq_is(1'h1);
    wr(REG_INT_CLR, 32'h4);
    irq_is(1'h0);
    rdc(REG_STATUS, 32'h0, RESP_OKAY);
    $display("test interrupt done");
    summarize();
  end
endmodule
